// *** src/dcwd_defs.svh ***
// Constants of the oscillator control-word decoder
// Assumes 16-bit serial words, address in the top two bits
`ifndef DCWD_DEFS_SVH
`define DCWD_DEFS_SVH

`define DCWD_WORD_BITS    16
`define DCWD_CNT_BITS     5
`define DCWD_HALF_BITS    14
`define DCWD_FREQ_BITS    28
`define DCWD_PHASE_BITS   12

`define DCWD_ADDR_CTRL    2'h0
`define DCWD_ADDR_FREQ_A  2'h1
`define DCWD_ADDR_FREQ_B  2'h2
`define DCWD_ADDR_PHASE   2'h3

`define DCWD_BIT_FULL     13
`define DCWD_BIT_HALF     12
`define DCWD_BIT_FCHOICE  11
`define DCWD_BIT_PCHOICE  10
`define DCWD_BIT_CLEAR    8
`define DCWD_BIT_GATE     7
`define DCWD_BIT_CONVOFF  6
`define DCWD_BIT_BITOUT   5
`define DCWD_BIT_UNDIV    3
`define DCWD_BIT_RAMP     1
`define DCWD_BIT_PHSEL    13

`define DCWD_CTRL_RESET   10'h000

`endif

// *** src/dcwd_pkg.sv ***
// Types shared by the control-word decoder files
// Assumes dcwd_defs.svh for widths
`include "dcwd_defs.svh"

package dcwd_pkg;

    typedef struct packed {
        logic full_word_load;
        logic half_select;
        logic frequency_choice;
        logic phase_choice;
        logic acc_clear;
        logic clock_gate;
        logic converter_off;
        logic bit_output_enable;
        logic msb_undivided;
        logic waveform_ramp;
    } dcwd_ctrl_t;

    typedef enum logic [1:0] {
        SRC_SINE,
        SRC_RAMP,
        SRC_MSB,
        SRC_HOLD
    } dcwd_src_t;

    typedef struct packed {
        logic                         valid;
        logic [`DCWD_WORD_BITS-1:0]   data;
    } dcwd_word_t;

endpackage

// *** src/dcwd_serial_rx.sv ***
// Three-wire serial word receiver
// Assumes pins asynchronous to sys clock; reset already synchronised
`timescale 1ns/10ps
`include "dcwd_defs.svh"
module dcwd_serial_rx (
    input  logic              clk_i,
    input  logic              rst_n_i,
    input  logic              sclk_i,
    input  logic              serial_in_i,
    input  logic              frame_sync_n_i,
    output dcwd_pkg::dcwd_word_t word_o
);
    import dcwd_pkg::*;

    logic [2:0]                  meta_q;
    logic [2:0]                  sync_q;
    logic                        sclk_prev_q;
    logic                        fs_prev_q;
    logic [`DCWD_WORD_BITS-1:0]  shift_q, shift_d;
    logic [`DCWD_CNT_BITS-1:0]   cnt_q, cnt_d;
    dcwd_word_t                  word_q, word_d;
    logic                        sclk_fall;
    logic                        frame_open;

    // Meta flop feeds only the second flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q      <= 3'h5;
            sync_q      <= 3'h5;
            sclk_prev_q <= 1'b0;
            fs_prev_q   <= 1'b1;
        end else begin
            meta_q      <= {frame_sync_n_i, serial_in_i, sclk_i};
            sync_q      <= meta_q;
            sclk_prev_q <= sync_q[0];
            fs_prev_q   <= sync_q[2];
        end
    end

    assign sclk_fall  = sclk_prev_q & ~sync_q[0];   // [RULE_14]
    assign frame_open = ~sync_q[2];

    always_comb begin
        shift_d    = shift_q;
        cnt_d      = cnt_q;
        word_d     = '0;
        word_d.data = word_q.data;
        if (!frame_open || fs_prev_q) begin
            // New frame or idle: drop any partial word
            cnt_d = '0;   // [RULE_15] [RULE_17]
        end
        if (frame_open && sclk_fall && cnt_q < `DCWD_CNT_BITS'(`DCWD_WORD_BITS)) begin
            shift_d = {shift_q[`DCWD_WORD_BITS-2:0], sync_q[1]};   // [RULE_14]
            cnt_d   = cnt_q + `DCWD_CNT_BITS'(1);
            if (cnt_q == `DCWD_CNT_BITS'(`DCWD_WORD_BITS - 1)) begin
                word_d.valid = 1'b1;   // [RULE_17]
                word_d.data  = {shift_q[`DCWD_WORD_BITS-2:0], sync_q[1]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= '0;
            cnt_q   <= '0;
            word_q  <= '0;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            word_q  <= word_d;
        end
    end

    assign word_o = word_q;

    a_word_after_16: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_17]
        word_q.valid |-> $past(cnt_q) == `DCWD_CNT_BITS'(15) && $past(sclk_fall) && $past(frame_open))
        else $error("word valid without sixteen bits");
    a_idle_no_word: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_15]
        !frame_open |=> !word_q.valid)
        else $error("word released outside a frame");

endmodule // dcwd_serial_rx

// *** src/dcwd_msb_out.sv ***
// Accumulator MSB output stage with optional divide by two
// Assumes acc_msb_i comes from logic on the same clock
`timescale 1ns/10ps
module dcwd_msb_out (
    input  logic clk_i,
    input  logic rst_n_i,
    input  logic acc_msb_i,
    input  logic hold_i,
    input  logic undivided_i,
    output logic bit_o
);
    logic msb_prev_q, msb_prev_d;
    logic half_q, half_d;
    logic bit_q, bit_d;

    always_comb begin
        msb_prev_d = msb_prev_q;
        half_d     = half_q;
        bit_d      = bit_q;
        // Gated clock freezes the pin at its present level
        if (!hold_i) begin   // [RULE_13]
            msb_prev_d = acc_msb_i;
            if (acc_msb_i && !msb_prev_q) begin
                half_d = ~half_q;
            end
            bit_d = undivided_i ? acc_msb_i : half_d;   // [RULE_09]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msb_prev_q <= 1'b0;
            half_q     <= 1'b0;
            bit_q      <= 1'b0;
        end else begin
            msb_prev_q <= msb_prev_d;
            half_q     <= half_d;
            bit_q      <= bit_d;
        end
    end

    assign bit_o = bit_q;

    a_div_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_09]
        !hold_i && !undivided_i && acc_msb_i && !msb_prev_q |=> half_q != $past(half_q) && bit_q == !$past(half_q))
        else $error("divided MSB did not toggle");
    a_hold_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_13]
        hold_i |=> bit_q == $past(bit_q))
        else $error("MSB output moved while gated");

endmodule // dcwd_msb_out

// *** src/dcwd_top.sv ***
// Control-word decoder for a direct digital synthesis oscillator
// Assumes serial pins asynchronous; accumulator MSB from sys clock logic
// Operation
// (RULE_01) Full-word mode: two writes to one frequency address, low half then high
// (RULE_02) Half-word mode: one write changes one 14-bit half, other kept
// (RULE_03) Half select set loads the high half, clear loads the low half
// (RULE_04) Frequency choice from bit 11, phase choice from bit 10
// (RULE_05) Host writes zero to reserved control bits 9, 4, 2 and 0
// (RULE_06) Accumulator clear bit 8 holds the accumulator at zero
// (RULE_07) Converter-off bit 6 powers the output converter down
// (RULE_08) Bit output enable routes accumulator MSB to the pin
// (RULE_09) Bit 3 clear divides the MSB by two, set passes it
// (RULE_10) Ramp bit clear, no gate, no bit output: sine through table
// (RULE_11) Ramp bit set, no gate, no bit output: table bypassed, ramp
// (RULE_12) Chosen frequency word is the increment, chosen phase is added
// (RULE_13) Clock gate set stops the internal clock, output holds
// (RULE_14) One data bit sampled on each falling serial clock edge
// (RULE_15) Frame sync low starts a new word
// (RULE_16) Top two bits pick control, frequency A, frequency B or phase
// (RULE_17) A word applies only after 16 bits in one frame
`timescale 1ns/10ps
`include "dcwd_defs.svh"
module dcwd_top (
    input  logic                         sys_clk_i,
    input  logic                         rstn_i,
    input  logic                         sclk_i,
    input  logic                         serial_in_i,
    input  logic                         frame_sync_n_i,
    input  logic                         acc_msb_i,
    output dcwd_pkg::dcwd_ctrl_t         ctrl_o,
    output logic [`DCWD_FREQ_BITS-1:0]   increment_o,
    output logic [`DCWD_PHASE_BITS-1:0]  phase_offset_o,
    output logic                         acc_clear_o,
    output logic                         acc_run_o,
    output logic                         converter_off_o,
    output dcwd_pkg::dcwd_src_t          out_src_o,
    output logic                         bit_out_o
);
    import dcwd_pkg::*;

    logic                         rst_meta_q;
    logic                         rst_n;
    dcwd_word_t                   word;
    logic [1:0]                   addr;
    logic [`DCWD_HALF_BITS-1:0]   fdata;
    logic                         fsel;

    dcwd_ctrl_t                   ctrl_q, ctrl_d;
    logic [`DCWD_FREQ_BITS-1:0]   freq_q [2];
    logic [`DCWD_FREQ_BITS-1:0]   freq_d [2];
    logic [`DCWD_HALF_BITS-1:0]   stage_q [2];
    logic [`DCWD_HALF_BITS-1:0]   stage_d [2];
    logic [1:0]                   pend_q, pend_d;
    logic [`DCWD_PHASE_BITS-1:0]  phase_q [2];
    logic [`DCWD_PHASE_BITS-1:0]  phase_d [2];

    logic [`DCWD_FREQ_BITS-1:0]   incr_q, incr_d;
    logic [`DCWD_PHASE_BITS-1:0]  poff_q, poff_d;
    dcwd_src_t                    src_q, src_d;
    dcwd_ctrl_t                   ctrl_out_q;
    logic                         clr_q, run_q, coff_q;

    // Reset released through two flops, asserted at once
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    dcwd_serial_rx u_rx (
        .clk_i          (sys_clk_i),
        .rst_n_i        (rst_n),
        .sclk_i         (sclk_i),
        .serial_in_i    (serial_in_i),
        .frame_sync_n_i (frame_sync_n_i),
        .word_o         (word)
    );

    dcwd_msb_out u_msb (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_n),
        .acc_msb_i   (acc_msb_i),
        .hold_i      (ctrl_q.clock_gate),
        .undivided_i (ctrl_q.msb_undivided),
        .bit_o       (bit_out_o)
    );

    // Output source priority: gate, then bit output, then waveform
    function automatic dcwd_src_t pick_src(input dcwd_ctrl_t c);
        if (c.clock_gate) begin
            pick_src = SRC_HOLD;   // [RULE_13]
        end else if (c.bit_output_enable) begin
            pick_src = SRC_MSB;    // [RULE_08]
        end else if (c.waveform_ramp) begin
            pick_src = SRC_RAMP;   // [RULE_11]
        end else begin
            pick_src = SRC_SINE;   // [RULE_10]
        end
    endfunction

    assign addr  = word.data[`DCWD_WORD_BITS-1 -: 2];
    assign fdata = word.data[`DCWD_HALF_BITS-1:0];
    assign fsel  = (addr == `DCWD_ADDR_FREQ_B);

    // Register update on each complete word
    always_comb begin
        ctrl_d  = ctrl_q;
        freq_d  = freq_q;
        stage_d = stage_q;
        pend_d  = pend_q;
        phase_d = phase_q;
        if (word.valid) begin   // [RULE_17]
            case (addr)   // [RULE_16]
                `DCWD_ADDR_CTRL: begin
                    // Reserved bits are not stored
                    ctrl_d.full_word_load    = word.data[`DCWD_BIT_FULL];
                    ctrl_d.half_select       = word.data[`DCWD_BIT_HALF];
                    ctrl_d.frequency_choice  = word.data[`DCWD_BIT_FCHOICE];   // [RULE_04]
                    ctrl_d.phase_choice      = word.data[`DCWD_BIT_PCHOICE];   // [RULE_04]
                    ctrl_d.acc_clear         = word.data[`DCWD_BIT_CLEAR];     // [RULE_06]
                    ctrl_d.clock_gate        = word.data[`DCWD_BIT_GATE];      // [RULE_13]
                    ctrl_d.converter_off     = word.data[`DCWD_BIT_CONVOFF];   // [RULE_07]
                    ctrl_d.bit_output_enable = word.data[`DCWD_BIT_BITOUT];    // [RULE_08]
                    ctrl_d.msb_undivided     = word.data[`DCWD_BIT_UNDIV];     // [RULE_09]
                    ctrl_d.waveform_ramp     = word.data[`DCWD_BIT_RAMP];      // [RULE_10] [RULE_11]
                    // Leaving or entering full-word mode drops a half-done pair
                    if (word.data[`DCWD_BIT_FULL] != ctrl_q.full_word_load) begin
                        pend_d = 2'h0;
                    end
                end
                `DCWD_ADDR_FREQ_A,
                `DCWD_ADDR_FREQ_B: begin
                    if (ctrl_q.full_word_load) begin
                        // Whole word commits at once so no torn increment is used
                        if (pend_q[fsel]) begin
                            freq_d[fsel] = {fdata, stage_q[fsel]};   // [RULE_01]
                            pend_d[fsel] = 1'b0;
                        end else begin
                            stage_d[fsel] = fdata;   // [RULE_01]
                            pend_d[fsel]  = 1'b1;
                        end
                    end else if (ctrl_q.half_select) begin
                        freq_d[fsel][`DCWD_FREQ_BITS-1:`DCWD_HALF_BITS] = fdata;   // [RULE_02] [RULE_03]
                    end else begin
                        freq_d[fsel][`DCWD_HALF_BITS-1:0] = fdata;   // [RULE_02] [RULE_03]
                    end
                end
                `DCWD_ADDR_PHASE: begin
                    phase_d[word.data[`DCWD_BIT_PHSEL]] = word.data[`DCWD_PHASE_BITS-1:0];
                end
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    // Registered outputs follow the new control state
    always_comb begin
        incr_d = freq_d[ctrl_d.frequency_choice];    // [RULE_12]
        poff_d = phase_d[ctrl_d.phase_choice];       // [RULE_12]
        src_d  = pick_src(ctrl_d);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= `DCWD_CTRL_RESET;
            freq_q     <= '{default: '0};
            stage_q    <= '{default: '0};
            pend_q     <= 2'h0;
            phase_q    <= '{default: '0};
            incr_q     <= '0;
            poff_q     <= '0;
            src_q      <= SRC_SINE;
            ctrl_out_q <= `DCWD_CTRL_RESET;
            clr_q      <= 1'b0;
            run_q      <= 1'b1;
            coff_q     <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            freq_q     <= freq_d;
            stage_q    <= stage_d;
            pend_q     <= pend_d;
            phase_q    <= phase_d;
            incr_q     <= incr_d;
            poff_q     <= poff_d;
            src_q      <= src_d;
            ctrl_out_q <= ctrl_d;
            clr_q      <= ctrl_d.acc_clear;        // [RULE_06]
            run_q      <= ~ctrl_d.clock_gate;      // [RULE_13]
            coff_q     <= ctrl_d.converter_off;    // [RULE_07]
        end
    end

    assign ctrl_o          = ctrl_out_q;
    assign increment_o     = incr_q;
    assign phase_offset_o  = poff_q;
    assign acc_clear_o     = clr_q;
    assign acc_run_o       = run_q;
    assign converter_off_o = coff_q;
    assign out_src_o       = src_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_first_half;
        word.valid && addr == `DCWD_ADDR_FREQ_A && ctrl_q.full_word_load && !pend_q[0];
    endsequence

    sequence s_second_half;
        word.valid && addr == `DCWD_ADDR_FREQ_A && ctrl_q.full_word_load && pend_q[0];
    endsequence

    a_full_first: assert property (s_first_half |=> freq_q[0] == $past(freq_q[0]) && pend_q[0]) // [RULE_01]
        else $error("first half changed the frequency word");
    // Second half may come many frames later; a delay range keeps the unrolling small
    a_full_pair: assert property (s_first_half ##[2:1000] s_second_half // [RULE_01]
        |=> freq_q[0] == {$past(fdata), $past(stage_q[0])} && !pend_q[0])
        else $error("full word not assembled low then high");
    a_half_high: assert property (word.valid && addr == `DCWD_ADDR_FREQ_B && !ctrl_q.full_word_load // [RULE_03]
        && ctrl_q.half_select |=> freq_q[1] == {$past(fdata), $past(freq_q[1][`DCWD_HALF_BITS-1:0])})
        else $error("high half write wrong");
    a_half_low: assert property (word.valid && addr == `DCWD_ADDR_FREQ_B && !ctrl_q.full_word_load // [RULE_02]
        && !ctrl_q.half_select |=> freq_q[1] == {$past(freq_q[1][`DCWD_FREQ_BITS-1:`DCWD_HALF_BITS]), $past(fdata)})
        else $error("low half write wrong");
    a_incr_select: assert property (##1 increment_o == freq_q[ctrl_q.frequency_choice] // [RULE_12]
        && phase_offset_o == phase_q[ctrl_q.phase_choice])
        else $error("increment or phase not the chosen register");
    a_clear_ctrl: assert property (word.valid && addr == `DCWD_ADDR_CTRL // [RULE_06]
        |=> acc_clear_o == $past(word.data[`DCWD_BIT_CLEAR]) && ctrl_q.frequency_choice == $past(word.data[`DCWD_BIT_FCHOICE]))
        else $error("control word not applied");
    a_conv_off: assert property (##1 converter_off_o == ctrl_q.converter_off) // [RULE_07]
        else $error("converter power state wrong");
    a_src_msb: assert property (##1 ctrl_q.bit_output_enable && !ctrl_q.clock_gate |-> out_src_o == SRC_MSB) // [RULE_08]
        else $error("MSB not routed to pin");
    a_src_sine: assert property (##1 !ctrl_q.waveform_ramp && !ctrl_q.clock_gate // [RULE_10]
        && !ctrl_q.bit_output_enable |-> out_src_o == SRC_SINE)
        else $error("sine source not chosen");
    a_src_ramp: assert property (##1 ctrl_q.waveform_ramp && !ctrl_q.clock_gate // [RULE_11]
        && !ctrl_q.bit_output_enable |-> out_src_o == SRC_RAMP)
        else $error("ramp source not chosen");
    a_gate_hold: assert property (##1 ctrl_q.clock_gate |-> out_src_o == SRC_HOLD && !acc_run_o) // [RULE_13]
        else $error("gate did not hold output");
    a_no_partial: assert property (!word.valid |=> ctrl_q == $past(ctrl_q) && pend_q == $past(pend_q)) // [RULE_17]
        else $error("state changed without a word");

endmodule // dcwd_top

// *** verif/dcwd_host_model.sv ***
// Host model: three-wire serial writer feeding the decoder
// Assumes clk_i is the 8 ns system clock; sclk half period is 4 cycles
`timescale 1ns/10ps
`include "dcwd_defs.svh"
module dcwd_host_model (
    input  logic clk_i,
    output logic sclk_o,
    output logic serial_in_o,
    output logic frame_sync_n_o
);
    initial begin
        sclk_o         = 1'b1;
        serial_in_o    = 1'b0;
        frame_sync_n_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Fewer than 16 bits aborts the frame, more adds junk bits
    task automatic send(input logic [15:0] w, input int n);
        logic [15:0] v;
        v = w;
        if (v[15:14] == `DCWD_ADDR_CTRL) v = v & 16'hfdea;
        frame_sync_n_o <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i++) begin
            serial_in_o <= (i < 16) ? v[15-i] : ~serial_in_o;
            sclk_o      <= 1'b1;
            wait_clk(4);
            sclk_o      <= 1'b0;
            wait_clk(4);
        end
        sclk_o <= 1'b1;
        wait_clk(4);
        // Released line shows the inverse, never a stale bit
        frame_sync_n_o <= 1'b1;
        serial_in_o    <= ~serial_in_o;
        wait_clk(4);
    endtask
endmodule // dcwd_host_model

// *** verif/testbench.sv ***
// Self-checking bench for the control-word decoder
// Assumes dcwd_top with the host model on its serial pins
`timescale 1ns/10ps
`include "dcwd_defs.svh"
module testbench;
    import dcwd_pkg::*;
    logic                          sys_clk, rstn, acc_msb, sclk, serial_in, frame_sync_n;
    dcwd_ctrl_t                    ctrl_o, m_ctrl;
    dcwd_src_t                     src_o;
    logic [`DCWD_FREQ_BITS-1:0]    inc_o;
    logic [`DCWD_FREQ_BITS-1:0]    m_freq [2];
    logic [`DCWD_PHASE_BITS-1:0]   ph_o;
    logic [`DCWD_PHASE_BITS-1:0]   m_phase [2];
    logic [`DCWD_HALF_BITS-1:0]    m_low [2];
    logic                          m_pend [2];
    logic                          clr_o, run_o, off_o, bit_o;
    int                            mismatches, n_tests, cycles;

    dcwd_host_model host (.clk_i(sys_clk), .sclk_o(sclk), .serial_in_o(serial_in), .frame_sync_n_o(frame_sync_n));

    dcwd_top dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .sclk_i(sclk), .serial_in_i(serial_in),
        .frame_sync_n_i(frame_sync_n), .acc_msb_i(acc_msb), .ctrl_o(ctrl_o), .increment_o(inc_o),
        .phase_offset_o(ph_o), .acc_clear_o(clr_o), .acc_run_o(run_o), .converter_off_o(off_o),
        .out_src_o(src_o), .bit_out_o(bit_o));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole bench is about 8000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic model(input logic [15:0] w);
        int a;
        a = w[14] ? 0 : 1;
        if (w[15:14] == `DCWD_ADDR_CTRL) begin
            if (w[13] !== m_ctrl.full_word_load) m_pend = '{1'b0, 1'b0};
            m_ctrl = {w[13:10], w[8:5], w[3], w[1]};
        end else if (w[15:14] == `DCWD_ADDR_PHASE) begin
            m_phase[w[13]] = w[11:0];
        end else if (m_ctrl.full_word_load) begin
            if (m_pend[a]) m_freq[a] = {w[13:0], m_low[a]};
            else m_low[a] = w[13:0];
            m_pend[a] = !m_pend[a];
        end else if (m_ctrl.half_select) begin
            m_freq[a][27:14] = w[13:0];
        end else begin
            m_freq[a][13:0] = w[13:0];
        end
    endtask

    task automatic check_all();
        dcwd_src_t src;
        src = m_ctrl.clock_gate ? SRC_HOLD : m_ctrl.bit_output_enable ? SRC_MSB :
              m_ctrl.waveform_ramp ? SRC_RAMP : SRC_SINE;
        check("ctrl", m_ctrl, ctrl_o);
        check("increment", m_freq[m_ctrl.frequency_choice], inc_o);
        check("phase", m_phase[m_ctrl.phase_choice], ph_o);
        check("clear", m_ctrl.acc_clear, clr_o);
        check("run", !m_ctrl.clock_gate, run_o);
        check("conv_off", m_ctrl.converter_off, off_o);
        check("source", src, src_o);
    endtask

    // A short frame must leave every output except bit_out alone
    task automatic send_chk(input logic [15:0] w, input int n);
        host.send(w, n);
        if (n >= 16) model(w);
        repeat (8) @(posedge sys_clk);
        check_all();
    endtask

    initial begin
        logic [15:0] w;
        logic        b0;
        int          k;
        rstn       = 1'b0;
        acc_msb    = 1'b0;
        mismatches = 0;
        n_tests    = 0;
        cycles     = 0;
        m_ctrl     = '0;
        m_freq     = '{28'h0, 28'h0};
        m_phase    = '{12'h0, 12'h0};
        m_pend     = '{1'b0, 1'b0};
        void'($urandom(32'h9d7e));
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check_all();
        send_chk(16'h1000, 16);
        send_chk(16'h5abc, 16);
        send_chk(16'h0000, 16);
        send_chk(16'h4123, 16);
        send_chk(16'h6fff, 15);
        send_chk(16'h2800, 16);
        send_chk(16'h8555, 16);
        send_chk(16'hbaaa, 20);
        send_chk(16'hec5a, 16);
        send_chk(16'h0585, 16);
        for (int i = 0; i < 40; i++) begin
            w = {2'($urandom_range(3, 0)), 14'($urandom())};
            send_chk(w, ($urandom_range(9, 0) == 0) ? 10 : 16);
        end
        send_chk(16'h0028, 16);
        repeat (12) begin
            acc_msb <= 1'($urandom_range(1, 0));
            repeat (4) @(posedge sys_clk);
            check("bit_out", acc_msb, bit_o);
        end
        send_chk(16'h0020, 16);
        acc_msb <= 1'b0;
        repeat (4) @(posedge sys_clk);
        b0 = bit_o;
        k  = 0;
        repeat (12) begin
            if (!acc_msb) k++;
            acc_msb <= ~acc_msb;
            repeat (4) @(posedge sys_clk);
            check("bit_out_div", b0 ^ k[0], bit_o);
        end
        send_chk(16'h00a0, 16);
        b0 = bit_o;
        repeat (8) begin
            acc_msb <= ~acc_msb;
            repeat (4) @(posedge sys_clk);
            check("bit_out_hold", b0, bit_o);
        end
        end_sim();
    end
endmodule // testbench
